// ==== hdl/pio_pkg.sv ====
// Constants for the parallel port group and host buffer
// Function
// - Three 8-bit, one 7-bit direction-programmable ports
// - One-bit input port, three-bit output port
// - First port direction by nibble, bits 4-5
// - Second port direction by pin pairs, bits 0-3
// - Reset: ports input, output buffers zero
// - Third port per-pin direction when bus off
// - Bus mode: third port is host address/strobes
// - Fourth port per-pin direction when bus off
// - Bus mode: fourth port is host data
// - Sixteen-byte shared buffer at FF90H-FF9FH
// - Writes always update port output register
// - Output pins read back written value
// - Input pins read external level
// - Mode and data registers at fixed addresses
// - Locations 7H/FH hold request flags
// - Simultaneous host and processor writes refused
package pio_pkg;
    localparam int ADDR_W = 16;
    localparam logic [15:0] ADR_AB_DIR = 16'hff28;
    localparam logic [15:0] ADR_C_MODE = 16'hff29;
    localparam logic [15:0] ADR_D_DIR = 16'hff2a;
    localparam logic [15:0] ADR_A_DATA = 16'hff2c;
    localparam logic [15:0] ADR_B_DATA = 16'hff2d;
    localparam logic [15:0] ADR_C_DATA = 16'hff2e;
    localparam logic [15:0] ADR_D_DATA = 16'hff2f;
    localparam logic [15:0] ADR_E_DATA = 16'hff57;
    localparam logic [15:0] ADR_F_DATA = 16'hff5c;
    localparam logic [11:0] ADR_BUF_BASE = 12'hff9;
    localparam logic [7:0] RST_AB_DIR = 8'h3f;
    localparam logic [7:0] RST_C_MODE = 8'h7f;
    localparam logic [7:0] RST_D_DIR = 8'hff;
    localparam logic [7:0] RST_DATA = 8'h00;
    localparam int BIT_BUS_SEL = 7;
    localparam int BIT_A_LO = 4;
    localparam int BIT_A_HI = 5;
    localparam int BIT_CS = 4;
    localparam int BIT_RD = 5;
    localparam int BIT_WR = 6;
    localparam logic [3:0] FLAG_LO = 4'h7;
    localparam logic [3:0] FLAG_HI = 4'hf;
endpackage

// ==== hdl/pio_shared_buf.sv ====
// Sixteen-byte shared buffer with request flag locations
`timescale 1ns/1ns
module pio_shared_buf (
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic cpu_we_i,
    input wire logic cpu_re_i,
    input wire logic [3:0] cpu_addr_i,
    input wire logic [7:0] cpu_wdata_i,
    output logic [7:0] cpu_rdata_o,
    input wire logic host_we_i,
    input wire logic host_acc_i,
    input wire logic [3:0] host_addr_i,
    input wire logic [7:0] host_wdata_i,
    output logic [7:0] host_rdata_o,
    output logic cpu_refused_o
);
    logic [7:0] mem_r [16];
    logic [6:0] flag_lo_r;
    logic [6:0] flag_hi_r;
    logic cpu_we_ok;
    logic host_we_ok;

    function automatic logic [7:0] rd(input logic [3:0] a, input logic [6:0] fl,
                                      input logic [6:0] fh, input logic [7:0] m);
        if (a == pio_pkg::FLAG_LO) begin
            return {1'b0, fl};
        end
        if (a == pio_pkg::FLAG_HI) begin
            return {1'b0, fh};
        end
        return m;
    endfunction

    // Concurrent writes from both sides are both refused
    assign cpu_we_ok = cpu_we_i && !host_we_i;
    assign host_we_ok = host_we_i && !cpu_we_i;
    assign cpu_refused_o = cpu_we_i && host_we_i;
    assign cpu_rdata_o = rd(cpu_addr_i, flag_lo_r, flag_hi_r, mem_r[cpu_addr_i]);
    assign host_rdata_o = rd(host_addr_i, flag_lo_r, flag_hi_r, mem_r[host_addr_i]);

    // Data storage
    always_ff @(posedge clk_sys_i) begin
        if (cpu_we_ok) begin
            mem_r[cpu_addr_i] <= cpu_wdata_i;
        end else if (host_we_ok) begin
            mem_r[host_addr_i] <= host_wdata_i;
        end
    end

    // Request flags: processor transfer sets, host access clears, set wins
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            flag_lo_r <= '0;
            flag_hi_r <= '0;
        end else begin
            for (int i = 0; i < 7; i++) begin
                if ((cpu_we_ok || cpu_re_i) && cpu_addr_i == 4'(i)) begin
                    flag_lo_r[i] <= 1'b1;
                end else if (host_acc_i && host_addr_i == 4'(i)) begin
                    flag_lo_r[i] <= 1'b0;
                end
                if ((cpu_we_ok || cpu_re_i) && cpu_addr_i == 4'(i + 8)) begin
                    flag_hi_r[i] <= 1'b1;
                end else if (host_acc_i && host_addr_i == 4'(i + 8)) begin
                    flag_hi_r[i] <= 1'b0;
                end
            end
        end
    end

    a_flag_set: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        cpu_we_ok && cpu_addr_i == 4'h0 |=> flag_lo_r[0])
        else $error("flag not set by processor transfer");
    a_write_refused: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        cpu_we_i && host_we_i |=> mem_r[$past(cpu_addr_i)] == $past(mem_r[cpu_addr_i]))
        else $error("simultaneous write not refused");
    c_conflict: cover property (@(posedge clk_sys_i) cpu_we_i && host_we_i);
endmodule // pio_shared_buf

// ==== hdl/pio_ports.sv ====
// Parallel port group with host bus mode
`timescale 1ns/1ns
module pio_ports (
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic [15:0] sfr_addr_i,
    input wire logic sfr_we_i,
    input wire logic sfr_re_i,
    input wire logic [7:0] sfr_wdata_i,
    output logic [7:0] sfr_rdata_o,
    output logic sfr_wr_refused_o,
    input wire logic [7:0] first_port_pin_i,
    output logic [7:0] first_port_pin_o,
    output logic [7:0] first_port_pin_oe_o,
    input wire logic [7:0] second_port_pin_i,
    output logic [7:0] second_port_pin_o,
    output logic [7:0] second_port_pin_oe_o,
    input wire logic [6:0] third_port_pin_i,
    output logic [6:0] third_port_pin_o,
    output logic [6:0] third_port_pin_oe_o,
    input wire logic [7:0] fourth_port_pin_i,
    output logic [7:0] fourth_port_pin_o,
    output logic [7:0] fourth_port_pin_oe_o,
    input wire logic fifth_port_pin_i,
    output logic [2:0] sixth_port_pin_o
);
    logic [7:0] port_ab_serial_direction_r;
    logic [7:0] port_c_mode_control_r;
    logic [7:0] port_d_direction_r;
    logic [7:0] a_out_r;
    logic [7:0] b_out_r;
    logic [6:0] c_out_r;
    logic [7:0] d_out_r;
    logic [2:0] f_out_r;
    logic [7:0] a_s1_r, a_s2_r, b_s1_r, b_s2_r, d_s1_r, d_s2_r;
    logic [6:0] c_s1_r, c_s2_r;
    logic e_s1_r, e_s2_r;
    logic wr_prev_r;
    logic [3:0] hold_addr_r;
    logic [7:0] hold_data_r;
    logic [7:0] host_rd_r;
    logic bus_mode;
    logic [7:0] a_in_dir, b_in_dir, d_in_dir;
    logic [6:0] c_in_dir;
    logic host_cs, host_rd, host_wr, host_we, host_acc;
    logic cpu_buf_sel;
    logic [7:0] buf_cpu_rdata, buf_host_rdata;
    logic [7:0] rdata_nxt;

    assign bus_mode = port_c_mode_control_r[pio_pkg::BIT_BUS_SEL];

    // Direction bit 1 means input
    assign a_in_dir = {{4{port_ab_serial_direction_r[pio_pkg::BIT_A_HI]}},
                       {4{port_ab_serial_direction_r[pio_pkg::BIT_A_LO]}}};
    assign b_in_dir = {{2{port_ab_serial_direction_r[3]}}, {2{port_ab_serial_direction_r[2]}},
                       {2{port_ab_serial_direction_r[1]}},
                       {2{port_ab_serial_direction_r[0]}}};
    assign c_in_dir = bus_mode ? 7'h7f : port_c_mode_control_r[6:0];
    assign d_in_dir = port_d_direction_r;

    // Pin synchronisers
    always_ff @(posedge clk_sys_i) begin
        a_s1_r <= first_port_pin_i;
        a_s2_r <= a_s1_r;
        b_s1_r <= second_port_pin_i;
        b_s2_r <= b_s1_r;
        c_s1_r <= third_port_pin_i;
        c_s2_r <= c_s1_r;
        d_s1_r <= fourth_port_pin_i;
        d_s2_r <= d_s1_r;
        e_s1_r <= fifth_port_pin_i;
        e_s2_r <= e_s1_r;
    end

    // Mode registers
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            port_ab_serial_direction_r <= pio_pkg::RST_AB_DIR;
            port_c_mode_control_r <= pio_pkg::RST_C_MODE;
            port_d_direction_r <= pio_pkg::RST_D_DIR;
        end else if (sfr_we_i) begin
            case (sfr_addr_i)
                pio_pkg::ADR_AB_DIR: port_ab_serial_direction_r <= sfr_wdata_i;
                pio_pkg::ADR_C_MODE: port_c_mode_control_r <= sfr_wdata_i;
                pio_pkg::ADR_D_DIR: port_d_direction_r <= sfr_wdata_i;
                default: ;
            endcase
        end
    end

    // Port output registers, written whatever the direction
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            a_out_r <= pio_pkg::RST_DATA;
            b_out_r <= pio_pkg::RST_DATA;
            c_out_r <= pio_pkg::RST_DATA[6:0];
            d_out_r <= pio_pkg::RST_DATA;
            f_out_r <= pio_pkg::RST_DATA[2:0];
        end else if (sfr_we_i) begin
            case (sfr_addr_i)
                pio_pkg::ADR_A_DATA: a_out_r <= sfr_wdata_i;
                pio_pkg::ADR_B_DATA: b_out_r <= sfr_wdata_i;
                pio_pkg::ADR_C_DATA: c_out_r <= sfr_wdata_i[6:0];
                pio_pkg::ADR_D_DATA: d_out_r <= sfr_wdata_i;
                pio_pkg::ADR_F_DATA: f_out_r <= sfr_wdata_i[2:0];
                default: ;
            endcase
        end
    end

    // Host bus decode on synchronised third port pins
    assign host_cs = !c_s2_r[pio_pkg::BIT_CS];
    assign host_rd = bus_mode && host_cs && !c_s2_r[pio_pkg::BIT_RD];
    assign host_wr = host_cs && !c_s2_r[pio_pkg::BIT_WR];
    assign host_we = bus_mode && wr_prev_r && !host_wr;
    assign host_acc = host_we || (host_rd && c_s2_r[pio_pkg::BIT_RD + 0] == 1'b0 &&
                                  !host_rd_r[0]);

    // Write strobe edge: latch address and data while strobe low
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            wr_prev_r <= 1'b0;
            hold_addr_r <= '0;
            hold_data_r <= '0;
            host_rd_r <= '0;
        end else begin
            wr_prev_r <= bus_mode && host_wr;
            host_rd_r <= {7'h00, host_rd};
            if (bus_mode && host_wr) begin
                hold_addr_r <= c_s2_r[3:0];
                hold_data_r <= d_s2_r;
            end
        end
    end

    assign cpu_buf_sel = sfr_addr_i[15:4] == pio_pkg::ADR_BUF_BASE;

    pio_shared_buf u_buf (
        .clk_sys_i(clk_sys_i),
        .srst_i(srst_i),
        .cpu_we_i(sfr_we_i && cpu_buf_sel),
        .cpu_re_i(sfr_re_i && cpu_buf_sel),
        .cpu_addr_i(sfr_addr_i[3:0]),
        .cpu_wdata_i(sfr_wdata_i),
        .cpu_rdata_o(buf_cpu_rdata),
        .host_we_i(host_we),
        .host_acc_i(host_acc),
        .host_addr_i(host_we ? hold_addr_r : c_s2_r[3:0]),
        .host_wdata_i(hold_data_r),
        .host_rdata_o(buf_host_rdata),
        .cpu_refused_o(sfr_wr_refused_o)
    );

    // Read mux: input pins return level, output pins return last write
    always_comb begin
        rdata_nxt = 8'h00;
        if (cpu_buf_sel) begin
            rdata_nxt = buf_cpu_rdata;
        end else begin
            case (sfr_addr_i)
                pio_pkg::ADR_AB_DIR: rdata_nxt = port_ab_serial_direction_r;
                pio_pkg::ADR_C_MODE: rdata_nxt = port_c_mode_control_r;
                pio_pkg::ADR_D_DIR: rdata_nxt = port_d_direction_r;
                pio_pkg::ADR_A_DATA: rdata_nxt = (a_in_dir & a_s2_r) | (~a_in_dir & a_out_r);
                pio_pkg::ADR_B_DATA: rdata_nxt = (b_in_dir & b_s2_r) | (~b_in_dir & b_out_r);
                pio_pkg::ADR_C_DATA: rdata_nxt = {1'b0, (c_in_dir & c_s2_r) | (~c_in_dir & c_out_r)};
                pio_pkg::ADR_D_DATA: rdata_nxt = (d_in_dir & d_s2_r) | (~d_in_dir & d_out_r);
                pio_pkg::ADR_E_DATA: rdata_nxt = {7'h00, e_s2_r};
                pio_pkg::ADR_F_DATA: rdata_nxt = {5'h00, f_out_r};
                default: rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            sfr_rdata_o <= 8'h00;
        end else begin
            sfr_rdata_o <= rdata_nxt;
        end
    end

    // Pin drivers
    assign first_port_pin_o = a_out_r;
    assign first_port_pin_oe_o = ~a_in_dir;
    assign second_port_pin_o = b_out_r;
    assign second_port_pin_oe_o = ~b_in_dir;
    assign third_port_pin_o = c_out_r;
    assign third_port_pin_oe_o = ~c_in_dir;
    assign fourth_port_pin_o = bus_mode ? buf_host_rdata : d_out_r;
    assign fourth_port_pin_oe_o = bus_mode ? {8{host_rd}} : ~d_in_dir;
    assign sixth_port_pin_o = f_out_r;

    a_reset_inputs: assert property (@(posedge clk_sys_i)
        srst_i |=> first_port_pin_oe_o == 8'h00 && fourth_port_pin_oe_o == 8'h00)
        else $error("ports not inputs after reset");
    a_bus_third_in: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        bus_mode |-> third_port_pin_oe_o == 7'h00)
        else $error("third port driven in bus mode");
    a_bus_drive: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        bus_mode && !host_rd |-> fourth_port_pin_oe_o == 8'h00)
        else $error("fourth port driven without host read");
    a_nibble_dir: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        first_port_pin_oe_o[7] == first_port_pin_oe_o[4])
        else $error("nibble direction split");
    a_pair_dir: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        second_port_pin_oe_o[1] == !port_ab_serial_direction_r[0])
        else $error("pair direction wrong");
    a_write_any_dir: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        sfr_we_i && sfr_addr_i == pio_pkg::ADR_A_DATA |=> a_out_r == $past(sfr_wdata_i))
        else $error("port write lost");
    a_read_output: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        sfr_addr_i == pio_pkg::ADR_F_DATA |=> sfr_rdata_o == {5'h00, $past(f_out_r)})
        else $error("output readback wrong");
    a_d_dir: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        !bus_mode |-> fourth_port_pin_oe_o == ~port_d_direction_r)
        else $error("fourth port direction wrong");
    c_bus_mode: cover property (@(posedge clk_sys_i) bus_mode && host_rd);
    c_host_write: cover property (@(posedge clk_sys_i) host_we);
    c_a_output: cover property (@(posedge clk_sys_i) first_port_pin_oe_o == 8'hff);
endmodule // pio_ports

// ==== verif/pio_host_model.sv ====
// Host computer model on the shared buffer bus
`timescale 1ns/1ns
module pio_host_model (
    input wire logic clk_sys_i,
    input wire logic slow_i,
    input wire logic [7:0] data_pin_i,
    output logic [6:0] ctrl_pin_o,
    output logic [7:0] data_pin_o
);
    logic [7:0] drv_r = 8'h00;
    logic drv_en_r = 1'b0;
    initial ctrl_pin_o = 7'h7f;
    // Released data lines show the inverse of the last value
    assign data_pin_o = drv_en_r ? drv_r : ~drv_r;
    task automatic strobe(input logic [3:0] adr, input int bit_n);
        int n;
        logic [6:0] c;
        n = slow_i ? 8 : 3;
        c = {3'b111, adr};
        c[4] = 1'b0;
        c[bit_n] = 1'b0;
        ctrl_pin_o = c;
        repeat (n) @(negedge clk_sys_i);
    endtask
    task automatic write_byte(input logic [3:0] adr, input logic [7:0] dat);
        @(negedge clk_sys_i);
        drv_r = dat;
        drv_en_r = 1'b1;
        strobe(adr, 6);
        ctrl_pin_o[6] = 1'b1;
        repeat (4) @(negedge clk_sys_i);
        ctrl_pin_o = 7'h7f;
        drv_en_r = 1'b0;
    endtask
    task automatic read_byte(input logic [3:0] adr, output logic [7:0] dat);
        @(negedge clk_sys_i);
        strobe(adr, 5);
        repeat (2) @(negedge clk_sys_i);
        dat = data_pin_i;
        ctrl_pin_o = 7'h7f;
    endtask
endmodule // pio_host_model

// ==== verif/parallel_io_ports_host_buffer_test.sv ====
// Self-checking bench for the parallel port group
`timescale 1ns/1ns
module parallel_io_ports_host_buffer_test;
    logic clk_sys_i = 1'b0;
    logic srst_i = 1'b1;
    logic [15:0] sfr_addr_i = 16'h0000;
    logic sfr_we_i = 1'b0;
    logic sfr_re_i = 1'b0;
    logic [7:0] sfr_wdata_i = 8'h00;
    logic [7:0] sfr_rdata_o, a_o, a_oe, b_o, b_oe, d_o, d_oe, host_d;
    logic [7:0] tb_a = 8'h00, tb_b = 8'h00, tb_d = 8'h00;
    logic [6:0] c_o, c_oe, host_c;
    logic [6:0] tb_c = 7'h00;
    logic [2:0] f_o;
    logic e_pin = 1'b0, bus_sel = 1'b0, slow = 1'b0;
    int n_mismatch = 0, n_compared = 0, cycles = 0;
    int mem[16], flg[16];
    pio_ports DUT (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .sfr_addr_i(sfr_addr_i),
        .sfr_we_i(sfr_we_i), .sfr_re_i(sfr_re_i), .sfr_wdata_i(sfr_wdata_i),
        .sfr_rdata_o(sfr_rdata_o), .sfr_wr_refused_o(),
        .first_port_pin_i((a_oe & a_o) | (~a_oe & tb_a)), .first_port_pin_o(a_o),
        .first_port_pin_oe_o(a_oe), .second_port_pin_i((b_oe & b_o) | (~b_oe & tb_b)),
        .second_port_pin_o(b_o), .second_port_pin_oe_o(b_oe),
        .third_port_pin_i((c_oe & c_o) | (~c_oe & (bus_sel ? host_c : tb_c))),
        .third_port_pin_o(c_o), .third_port_pin_oe_o(c_oe),
        .fourth_port_pin_i((d_oe & d_o) | (~d_oe & (bus_sel ? host_d : tb_d))),
        .fourth_port_pin_o(d_o), .fourth_port_pin_oe_o(d_oe),
        .fifth_port_pin_i(e_pin), .sixth_port_pin_o(f_o));
    pio_host_model u_host (.clk_sys_i(clk_sys_i), .slow_i(slow),
        .data_pin_i((d_oe & d_o) | (~d_oe & host_d)), .ctrl_pin_o(host_c),
        .data_pin_o(host_d));
    always #5 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            final_report();
        end
    end
    task automatic final_report();
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk_reg(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_pin(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected pin %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic sfr_wr(input logic [15:0] adr, input logic [7:0] dat);
        @(negedge clk_sys_i);
        sfr_addr_i = adr;
        sfr_wdata_i = dat;
        sfr_we_i = 1'b1;
        @(negedge clk_sys_i);
        sfr_we_i = 1'b0;
    endtask
    task automatic sfr_rd(input logic [15:0] adr, output logic [7:0] dat);
        @(negedge clk_sys_i);
        sfr_addr_i = adr;
        sfr_re_i = 1'b1;
        @(negedge clk_sys_i);
        dat = sfr_rdata_o;
        sfr_re_i = 1'b0;
    endtask
    task automatic rd_chk(input logic [15:0] adr, input logic [7:0] e);
        logic [7:0] v;
        sfr_rd(adr, v);
        chk_reg("register", e, v);
    endtask
    function automatic logic [7:0] buf_exp(input int i);
        logic [7:0] v;
        v = 8'h00;
        if (i % 8 != 7) return mem[i][7:0];
        for (int k = 0; k < 7; k++) v[k] = flg[i - 7 + k][0];
        return v;
    endfunction
    task automatic rd_buf(input int i);
        rd_chk(16'hff90 + 16'(i), buf_exp(i));
        if (i % 8 != 7) flg[i] = 1;
    endtask
    initial begin
        logic [7:0] v, ab, cm, dd;
        logic [7:0] dat[4], eoe[4], poe[4], po[4], tbv[4];
        logic [15:0] radr[8] = '{16'hff28, 16'hff29, 16'hff2a, 16'hff2c, 16'hff2d,
            16'hff2e, 16'hff2f, 16'hff5c};
        logic [7:0] rval[8] = '{8'h3f, 8'h7f, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        int i, k;
        i = $urandom(59525);
        repeat (8) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        srst_i = 1'b0;
        for (i = 0; i < 8; i++) rd_chk(radr[i], rval[i]);
        chk_pin("oe", 8'h00, a_oe | b_oe | d_oe | {1'b0, c_oe});
        for (i = 0; i < 6; i++) begin
            ab = 8'($urandom) & 8'h3f;
            cm = 8'($urandom) & 8'h7f;
            dd = 8'($urandom);
            sfr_wr(16'hff28, ab);
            sfr_wr(16'hff29, cm);
            sfr_wr(16'hff2a, dd);
            for (k = 0; k < 4; k++) dat[k] = 8'($urandom);
            for (k = 0; k < 4; k++) sfr_wr(16'hff2c + 16'(k), dat[k]);
            dat[2][7] = 1'b0;
            {tb_a, tb_b, tb_c, tb_d, e_pin} = 32'($urandom);
            sfr_wr(16'hff5c, dat[0]);
            sfr_wr(16'hff57, 8'hff);
            repeat (4) @(negedge clk_sys_i);
            chk_pin("sixth", {5'h00, dat[0][2:0]}, {5'h00, f_o});
            rd_chk(16'hff5c, {5'h00, dat[0][2:0]});
            rd_chk(16'hff57, {7'h00, e_pin});
            rd_chk(16'hff30, 8'h00);
            rd_chk(16'hff28, ab);
            rd_chk(16'hff29, cm);
            rd_chk(16'hff2a, dd);
            for (k = 0; k < 4; k++) eoe[k] = ~dd;
            eoe[0] = {{4{~ab[5]}}, {4{~ab[4]}}};
            for (k = 0; k < 4; k++) eoe[1][2 * k +: 2] = {2{~ab[k]}};
            eoe[2] = {1'b0, ~cm[6:0]};
            poe = '{a_oe, b_oe, {1'b0, c_oe}, d_oe};
            po = '{a_o, b_o, {1'b0, c_o}, d_o};
            tbv = '{tb_a, tb_b, {1'b0, tb_c}, tb_d};
            for (k = 0; k < 4; k++) begin
                chk_pin("oe", eoe[k], poe[k]);
                chk_pin("out", dat[k], po[k]);
                rd_chk(16'hff2c + 16'(k), (dat[k] & eoe[k]) | (tbv[k] & ~eoe[k]));
            end
        end
        for (i = 0; i < 16; i++) begin
            mem[i] = $urandom & 255;
            sfr_wr(16'hff90 + 16'(i), mem[i][7:0]);
            if (i % 8 != 7) flg[i] = 1;
        end
        for (i = 0; i < 16; i++) rd_buf(i);
        tb_c = 7'h7f;
        sfr_wr(16'hff2a, 8'h00);
        sfr_wr(16'hff29, 8'h80);
        bus_sel = 1'b1;
        repeat (4) @(negedge clk_sys_i);
        chk_pin("bus_oe", 8'h00, {1'b0, c_oe} | d_oe);
        for (i = 0; i < 4; i++) begin
            k = $urandom % 7 + (i[0] ? 8 : 0);
            slow = i[1];
            u_host.read_byte(k[3:0], v);
            chk_pin("host_read", mem[k][7:0], v);
            flg[k] = 0;
            rd_buf(k | 7);
            v = 8'($urandom);
            u_host.write_byte(k[3:0], v);
            mem[k] = v;
            rd_buf(k | 7);
            rd_buf(k);
            chk_pin("idle_oe", 8'h00, d_oe);
        end
        final_report();
    end
endmodule // parallel_io_ports_host_buffer_test
